// ===== include/eeprom_ops_pkg.sv
// Constants, types and behaviour notes for the program-memory load and flag unit
// Notes on behaviour
// - Configuration-word instruction spans three bytes holding a 24-bit literal, stored not executed.
// - Bytes 0 through 47 form sixteen consecutive 24-bit configuration registers.
// - User code begins at program-memory byte 48.
// - Memory load reads word at RAM pointer into x, y, z or r, updating S and Z.
// - Memory load is one byte and takes six clock cycles.
// - Memory load holds one program counter stack entry until it completes.
// - Flag refresh sets sign when the register is negative, else clears it.
// - Flag refresh sets nonzero when the register differs from zero, else clears it.
// - Flag refresh keeps the register value and finishes in one cycle.
// - Pointer-decrement instruction lowers the RAM pointer by one in one cycle.
package eeprom_ops_pkg;
   localparam int WORD_W = 24;
   localparam int PTR_W = 8;
   localparam int MADDR_W = 13;
   localparam int CFG_REGS = 16;
   localparam int CFG_IDX_W = 4;
   localparam int CFG_WORD_BYTES = 3;
   localparam logic [MADDR_W-1:0] USER_CODE_BASE = 13'h0030;
   localparam logic [2:0] LOAD_CYCLES = 3'h6;
   localparam logic [2:0] LOAD_LAST = 3'h5;
   localparam logic [PTR_W-1:0] PTR_STEP = 8'h01;

   typedef enum logic [2:0] {
      OP_NONE,
      OP_CFG_WORD,
      OP_MEM_LOAD,
      OP_FLAG_REFRESH,
      OP_PTR_DEC
   } op_e;

   typedef struct packed {
      logic carry;
      logic overflow;
      logic sign;
      logic nonzero;
   } flags_s;

   typedef struct packed {
      logic valid;
      op_e op;
      logic [1:0] reg_sel;
      logic [WORD_W-1:0] literal;
   } instr_s;

   typedef struct packed {
      logic req;
      logic [MADDR_W-1:0] addr;
   } mem_req_s;
endpackage

// ===== hdl/eeprom_load_and_flag_ops.sv
// Executes configuration-word, memory-load, flag-refresh and pointer-decrement instructions
module eeprom_load_and_flag_ops (
   input wire logic clk,
   input wire logic rstn,
   input wire eeprom_ops_pkg::instr_s instr,
   output logic busy,
   output logic done,
   input wire logic [eeprom_ops_pkg::WORD_W-1:0] mem_rdata,
   output eeprom_ops_pkg::mem_req_s mem_req,
   output logic cfg_we,
   output logic [eeprom_ops_pkg::CFG_IDX_W-1:0] cfg_idx,
   output logic [eeprom_ops_pkg::WORD_W-1:0] cfg_wdata,
   output logic [eeprom_ops_pkg::MADDR_W-1:0] user_code_base,
   input wire logic [eeprom_ops_pkg::WORD_W-1:0] wr_in [4],
   output logic wr_we,
   output logic [1:0] wr_sel,
   output logic [eeprom_ops_pkg::WORD_W-1:0] wr_wdata,
   input wire eeprom_ops_pkg::flags_s flags_in,
   output eeprom_ops_pkg::flags_s flags,
   output logic stack_hold,
   output logic [eeprom_ops_pkg::PTR_W-1:0] ram_ptr
);
   import eeprom_ops_pkg::*;

   typedef enum logic {IDLE, LOADING} state_e;

   state_e state, next_state;
   logic [2:0] cnt, next_cnt;
   logic [1:0] sel, next_sel;
   logic [CFG_IDX_W:0] cfg_count, next_cfg_count;
   logic [PTR_W-1:0] next_ram_ptr;
   logic next_cfg_we, next_wr_we, next_done;
   logic [CFG_IDX_W-1:0] next_cfg_idx;
   logic [WORD_W-1:0] next_cfg_wdata, next_wr_wdata;
   logic [1:0] next_wr_sel;
   flags_s next_flags;

   function automatic flags_s refresh(input flags_s f, input logic [WORD_W-1:0] v);
      flags_s r;
      r = f;
      r.sign = v[WORD_W-1];
      r.nonzero = |v;
      return r;
   endfunction

   assign busy = (state == LOADING);
   assign stack_hold = (state == LOADING);
   assign user_code_base = USER_CODE_BASE;
   assign mem_req.req = (state == LOADING) && (cnt == '0);
   assign mem_req.addr = {{(MADDR_W-PTR_W){1'b0}}, ram_ptr};

   always_comb begin
      next_state = state;
      next_cnt = cnt;
      next_sel = sel;
      next_cfg_count = cfg_count;
      next_ram_ptr = ram_ptr;
      next_cfg_we = 1'b0;
      next_cfg_idx = cfg_idx;
      next_cfg_wdata = cfg_wdata;
      next_wr_we = 1'b0;
      next_wr_sel = wr_sel;
      next_wr_wdata = wr_wdata;
      next_flags = flags_in;
      next_done = 1'b0;
      case (state)
         IDLE: begin
            if (instr.valid) begin
               case (instr.op)
                  OP_CFG_WORD: begin
                     // Only the first sixteen land in the config area; later ones are dropped
                     if (cfg_count < 5'(CFG_REGS)) begin
                        next_cfg_we = 1'b1;
                        next_cfg_idx = cfg_count[CFG_IDX_W-1:0];
                        next_cfg_wdata = instr.literal;
                        next_cfg_count = cfg_count + 5'h01;
                     end
                     next_done = 1'b1;
                  end
                  OP_MEM_LOAD: begin
                     next_state = LOADING;
                     next_cnt = '0;
                     next_sel = instr.reg_sel;
                  end
                  OP_FLAG_REFRESH: begin
                     next_flags = refresh(flags_in, wr_in[instr.reg_sel]);
                     next_done = 1'b1;
                  end
                  OP_PTR_DEC: begin
                     next_ram_ptr = ram_ptr - PTR_STEP;
                     next_done = 1'b1;
                  end
                  default: begin
                  end
               endcase
            end
         end
         LOADING: begin
            next_cnt = cnt + 3'h1;
            if (cnt == LOAD_LAST - 3'h1) begin
               next_state = IDLE;
               next_wr_we = 1'b1;
               next_wr_sel = sel;
               next_wr_wdata = mem_rdata;
               next_flags = refresh(flags_in, mem_rdata);
               next_done = 1'b1;
            end
         end
         default: next_state = IDLE;
      endcase
   end

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         state <= IDLE;
         cnt <= '0;
         sel <= '0;
         cfg_count <= '0;
         ram_ptr <= '0;
         cfg_we <= 1'b0;
         cfg_idx <= '0;
         cfg_wdata <= '0;
         wr_we <= 1'b0;
         wr_sel <= '0;
         wr_wdata <= '0;
         flags <= '0;
         done <= 1'b0;
      end else begin
         state <= next_state;
         cnt <= next_cnt;
         sel <= next_sel;
         cfg_count <= next_cfg_count;
         ram_ptr <= next_ram_ptr;
         cfg_we <= next_cfg_we;
         cfg_idx <= next_cfg_idx;
         cfg_wdata <= next_cfg_wdata;
         wr_we <= next_wr_we;
         wr_sel <= next_wr_sel;
         wr_wdata <= next_wr_wdata;
         flags <= next_flags;
         done <= next_done;
      end
   end

   // Load: accepted edge plus five busy edges gives six cycles to done
   property p_load_six;
      @(posedge clk) disable iff (!rstn)
      (!busy && instr.valid && instr.op == OP_MEM_LOAD) |=> busy [*5] ##1 (done && wr_we);
   endproperty
   a_load_six: assert property (p_load_six) else $error("load not six cycles");

   property p_stack;
      @(posedge clk) disable iff (!rstn) $fell(busy) |-> !stack_hold && done;
   endproperty
   a_stack: assert property (p_stack) else $error("stack entry not released");

   property p_load_data;
      @(posedge clk) disable iff (!rstn)
      wr_we |-> wr_wdata == $past(mem_rdata) && flags.nonzero == (|wr_wdata);
   endproperty
   a_load_data: assert property (p_load_data) else $error("load data wrong");

   property p_sign;
      @(posedge clk) disable iff (!rstn)
      (!busy && instr.valid && instr.op == OP_FLAG_REFRESH)
      |=> flags.sign == $past(wr_in[instr.reg_sel][WORD_W-1]);
   endproperty
   a_sign: assert property (p_sign) else $error("sign flag wrong");

   property p_nz;
      @(posedge clk) disable iff (!rstn)
      (!busy && instr.valid && instr.op == OP_FLAG_REFRESH)
      |=> flags.nonzero == $past(|wr_in[instr.reg_sel]) && done && !wr_we;
   endproperty
   a_nz: assert property (p_nz) else $error("nonzero flag wrong");

   property p_cv;
      @(posedge clk) disable iff (!rstn)
      ##1 (flags.carry == $past(flags_in.carry) && flags.overflow == $past(flags_in.overflow));
   endproperty
   a_cv: assert property (p_cv) else $error("carry or overflow changed");

   property p_dec;
      @(posedge clk) disable iff (!rstn)
      (!busy && instr.valid && instr.op == OP_PTR_DEC) |=> ram_ptr == $past(ram_ptr) - PTR_STEP;
   endproperty
   a_dec: assert property (p_dec) else $error("pointer not decremented");

   property p_cfg;
      @(posedge clk) disable iff (!rstn)
      (!busy && instr.valid && instr.op == OP_CFG_WORD && cfg_count < 5'(CFG_REGS))
      |=> cfg_we && cfg_wdata == $past(instr.literal) && !wr_we;
   endproperty
   a_cfg: assert property (p_cfg) else $error("config word not stored");

   // A word beyond the sixteenth still completes but must not reach the area
   property p_cfg_full;
      @(posedge clk) disable iff (!rstn)
      (!busy && instr.valid && instr.op == OP_CFG_WORD && cfg_count == 5'(CFG_REGS))
      |=> !cfg_we && done;
   endproperty
   a_cfg_full: assert property (p_cfg_full) else $error("word past config area");

   property p_mem_req;
      @(posedge clk) disable iff (!rstn)
      $rose(busy) |-> mem_req.req && mem_req.addr == MADDR_W'(ram_ptr) ##1 !mem_req.req;
   endproperty
   a_mem_req: assert property (p_mem_req) else $error("memory request wrong");

   // Sequencer may keep valid high during a load; neither the pointer nor the config area may move
   property p_busy_quiet;
      @(posedge clk) disable iff (!rstn)
      busy |=> $stable(ram_ptr) && !cfg_we;
   endproperty
   a_busy_quiet: assert property (p_busy_quiet) else $error("taken while busy");

   property p_idle_quiet;
      @(posedge clk) disable iff (!rstn)
      (!busy && (!instr.valid || instr.op == OP_NONE))
      |=> !done && !cfg_we && !wr_we && $stable(ram_ptr);
   endproperty
   a_idle_quiet: assert property (p_idle_quiet) else $error("idle output moved");

   c_load: cover property (@(posedge clk) disable iff (!rstn) wr_we && wr_wdata[WORD_W-1]);
   c_cfg_full: cover property (@(posedge clk) disable iff (!rstn)
      cfg_we && cfg_idx == CFG_IDX_W'(CFG_REGS - 1));
   c_dec_load: cover property (@(posedge clk) disable iff (!rstn)
      instr.valid && instr.op == OP_PTR_DEC ##1 instr.valid && instr.op == OP_MEM_LOAD);
   c_cfg_drop: cover property (@(posedge clk) disable iff (!rstn)
      !busy && instr.valid && instr.op == OP_CFG_WORD && cfg_count == 5'(CFG_REGS));
endmodule // eeprom_load_and_flag_ops

// ===== verification/prog_mem_model.sv
// Program memory model answering load requests after a set latency
module prog_mem_model
   import eeprom_ops_pkg::*;
(
   input wire logic clk,
   input wire logic rstn,
   input wire mem_req_s mem_req,
   input wire logic busy,
   output logic [WORD_W-1:0] mem_rdata
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [WORD_W-1:0] mem [2**MADDR_W];
   logic [MADDR_W-1:0] addr;
   int age;
   int lat = 1;
   // Bus toggles outside a read so stale data never looks valid
   always @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         age <= 0;
         mem_rdata <= 24'h5A5A5A;
      end else if (mem_req.req) begin
         addr <= mem_req.addr;
         age <= 1;
         mem_rdata <= ~mem_rdata;
      end else if (age > 0 && busy) begin
         age <= age + 1;
         mem_rdata <= (age >= lat) ? mem[addr] : ~mem_rdata;
      end else begin
         age <= 0;
         mem_rdata <= ~mem_rdata;
      end
   end
endmodule // prog_mem_model

// ===== verification/testbench.sv
// Self-checking bench for the load, flag and configuration unit
module testbench;
   timeunit 1ns;
   timeprecision 1ns;
   import eeprom_ops_pkg::*;
   `define CHK(n, e, s) begin samples_checked++; if ((e) !== (s)) begin fails++; \
      $display("[ERR] %s exp %h got %h", n, e, s); end end
   logic clk = 0, rstn = 0, busy, done, cfg_we, wr_we, stack_hold;
   instr_s instr = '0;
   flags_s flags_in = '0, flags;
   mem_req_s mem_req;
   logic [WORD_W-1:0] mem_rdata, cfg_wdata, wr_wdata, v, cw = '0, lw = '0;
   logic [WORD_W-1:0] wr_in [4] = '{default: '0};
   logic [CFG_IDX_W-1:0] cfg_idx, ci = '0;
   logic [MADDR_W-1:0] user_code_base;
   logic [1:0] wr_sel, ls = '0;
   logic [PTR_W-1:0] ram_ptr, ptr = '0;
   logic [67:0] q[$], e;
   int fails = 0, samples_checked = 0, seed = 46260, n, k;
   always #2 clk = ~clk;
   eeprom_load_and_flag_ops uut (
      .clk(clk),
      .rstn(rstn),
      .instr(instr),
      .busy(busy),
      .done(done),
      .mem_rdata(mem_rdata),
      .mem_req(mem_req),
      .cfg_we(cfg_we),
      .cfg_idx(cfg_idx),
      .cfg_wdata(cfg_wdata),
      .user_code_base(user_code_base),
      .wr_in(wr_in),
      .wr_we(wr_we),
      .wr_sel(wr_sel),
      .wr_wdata(wr_wdata),
      .flags_in(flags_in),
      .flags(flags),
      .stack_hold(stack_hold),
      .ram_ptr(ram_ptr)
   );
   prog_mem_model pm (
      .clk(clk),
      .rstn(rstn),
      .mem_req(mem_req),
      .busy(busy),
      .mem_rdata(mem_rdata)
   );
   task automatic wrap_up();
      $display("checks %0d fails %0d", samples_checked, fails);
      if (fails == 0 && samples_checked > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask
   function automatic void note(logic c, logic w, flags_s f);
      q.push_back({c, ci, cw, w, ls, lw, f, ptr});
   endfunction
   task automatic go(op_e op, logic [1:0] s, logic [WORD_W-1:0] l);
      instr = '{1'b1, op, s, l};
      @(posedge clk);
      #1;
   endtask
   always @(negedge clk) if (done === 1'b1) begin
      e = q.size() ? q.pop_front() : ~68'h0;
      `CHK("outputs", e, {cfg_we, cfg_idx, cfg_wdata, wr_we, wr_sel, wr_wdata, flags, ram_ptr})
   end
   initial begin
      #100000;
      fails++;
      wrap_up();
   end
   initial begin
      flags_in = flags_s'($random(seed));
      repeat (3) @(posedge clk);
      #1 rstn = 1;
      // Seventeen back-to-back words: the last one finds the area full
      for (n = 0; n < 17; n++) begin
         v = $random(seed);
         if (n < 16) begin
            ci = n[3:0];
            cw = v;
         end
         note(n < 16, 1'b0, flags_in);
         go(OP_CFG_WORD, 2'h0, v);
      end
      `CHK("code base", 13'h0030, user_code_base)
      for (n = 0; n < 8; n++) begin
         for (k = 0; k < 4; k++) wr_in[k] = $random(seed);
         v = n == 0 ? 24'h0 : n == 1 ? 24'h800000 : n == 2 ? 24'h7FFFFF : $random(seed);
         wr_in[n[1:0]] = v;
         flags_in = flags_s'($random(seed));
         note(1'b0, 1'b0, {flags_in.carry, flags_in.overflow, v[23], |v});
         go(OP_FLAG_REFRESH, n[1:0], 24'h0);
      end
      // No-op (OP_NONE): no note, so any done it raised would be a mismatch
      go(OP_NONE, 2'h0, 24'h0);
      for (n = 0; n < 4; n++) begin
         v = n == 0 ? 24'h0 : n == 1 ? 24'h800000 : $random(seed);
         pm.mem[{5'h0, ptr}] = v;
         pm.lat = n[0] ? 2 : 1;
         ls = n[1:0];
         lw = v;
         note(1'b0, 1'b1, {flags_in.carry, flags_in.overflow, v[23], |v});
         go(OP_MEM_LOAD, n[1:0], 24'h0);
         `CHK("mem req", {1'b1, 5'h0, ptr}, mem_req)
         instr.op = OP_PTR_DEC; // Must be ignored while busy
         for (k = 0; k < 5; k++) begin
            `CHK("busy", 2'h3, {busy, stack_hold})
            if (k == 3) instr.valid = 1'b0;
            @(posedge clk);
            #1;
         end
         `CHK("released", 2'h0, {busy, stack_hold})
         ptr = ptr - 8'h01;
         note(1'b0, 1'b0, flags_in);
         go(OP_PTR_DEC, 2'h0, 24'h0);
      end
      instr.valid = 1'b0;
      for (k = 0; k < 20 && q.size() > 0; k++) @(posedge clk);
      `CHK("pending", 0, q.size())
      wrap_up();
   end
endmodule // testbench
